// [design/flash_lock_pkg.sv]
// Constants for the lock, quad-exit and software reset instruction block
package flash_lock_pkg;
    localparam logic [7:0] OP_EXIT_QUAD = 8'hFF;
    localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
    localparam logic [7:0] OP_LOCK = 8'h36;
    localparam logic [7:0] OP_UNLOCK = 8'h39;
    localparam logic [7:0] OP_READ_LOCK = 8'h3D;
    localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7E;
    localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
    localparam logic [7:0] OP_RESET_ARM = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;
    localparam logic [5:0] OPCODE_BITS = 6'h08;
    localparam logic [5:0] CMD_BITS = 6'h20;
    localparam int NUM_BLOCKS = 256;
    localparam int BLOCK_LSB = 16;
    localparam logic [NUM_BLOCKS-1:0] LOCKS_RESET = '1;
    localparam logic [7:0] LOCKED_BYTE = 8'h01;
    localparam logic [7:0] UNLOCKED_BYTE = 8'h00;
    localparam int CLK_HZ = 10000000;
    localparam int RESET_TIME_US = 100;
    // Least time, so round up to whole cycles
    localparam int RESET_CYC_INT =
        (CLK_HZ / 1000 * RESET_TIME_US + 999) / 1000;
    localparam logic [9:0] RESET_CYCLES = 10'(RESET_CYC_INT);
endpackage

// [design/flash_lock_cmd.sv]
// Lock, quad-exit and software reset instruction interpreter
`timescale 1ns/100ps
module flash_lock_cmd
    import flash_lock_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic [3:0] io_i,
    output logic [3:0] io_o,
    output logic [3:0] io_oe_o,
    input wire logic lock_select_bit_i,
    input wire logic quad_enable_bit_i,
    input wire logic block_protect_hit_i,
    input wire logic wel_set_i,
    input wire logic wel_clear_i,
    input wire logic pe_req_i,
    input wire logic [23:0] pe_addr_i,
    output logic pe_grant_o,
    output logic pe_deny_o,
    output logic write_enable_latch_o,
    output logic quad_instruction_mode_o,
    output logic soft_reset_o,
    output logic reset_busy_o
);
    typedef struct packed {
        logic cs1;
        logic cs2;
        logic cs3;
        logic ck1;
        logic ck2;
        logic ck3;
        logic [3:0] io1;
        logic [3:0] io2;
        logic qpi;
        logic write_enable_latch;
        logic armed;
        logic busy;
        logic [9:0] rst_cnt;
        logic [5:0] cnt;
        logic [7:0] op;
        logic [31:0] sh;
        logic [NUM_BLOCKS-1:0] locks;
        logic [7:0] out_sh;
        logic [3:0] io_out;
        logic [3:0] io_oe;
        logic pe_grant;
        logic pe_deny;
        logic soft_reset;
    } state_t;

    state_t r_reg;
    state_t r_next;
    logic ck_rise;
    logic ck_fall;
    logic cs_rise;
    logic [7:0] blk;

    // Every check below runs on the system clock, quiet in reset
    default clocking chk_cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    assign ck_rise = r_reg.ck2 & ~r_reg.ck3;
    assign ck_fall = ~r_reg.ck2 & r_reg.ck3;
    assign cs_rise = r_reg.cs2 & ~r_reg.cs3;
    assign blk = r_reg.sh[BLOCK_LSB +: 8];

    // Next-state logic for the whole interpreter
    always_comb begin
        r_next = r_reg;
        r_next.soft_reset = 1'b0;
        r_next.pe_grant = 1'b0;
        r_next.pe_deny = 1'b0;
        // Pins pass two flops before use; first stage feeds only the second
        r_next.cs1 = cs_n_i;
        r_next.cs2 = r_reg.cs1;
        r_next.cs3 = r_reg.cs2;
        r_next.ck1 = sclk_i;
        r_next.ck2 = r_reg.ck1;
        r_next.ck3 = r_reg.ck2;
        r_next.io1 = io_i;
        r_next.io2 = r_reg.io1;
        // Write enable comes from the neighbouring decoder; set wins
        if (wel_clear_i) begin
            r_next.write_enable_latch = 1'b0;
        end
        if (wel_set_i) begin
            r_next.write_enable_latch = 1'b1;
        end
        // Shift in opcode and address on rising edges
        if (!r_reg.cs2 && ck_rise && r_reg.cnt < CMD_BITS) begin
            if (r_reg.qpi) begin
                r_next.sh = {r_reg.sh[27:0], r_reg.io2};
                r_next.cnt = r_reg.cnt + 6'h04;
            end else begin
                r_next.sh = {r_reg.sh[30:0], r_reg.io2[0]};
                r_next.cnt = r_reg.cnt + 6'h01;
            end
            if (r_next.cnt == OPCODE_BITS) begin
                r_next.op = r_next.sh[7:0];
            end
            // Status byte is fixed once the address is complete
            if (r_next.cnt == CMD_BITS && r_reg.op == OP_READ_LOCK) begin
                r_next.out_sh = r_reg.locks[r_next.sh[23:16]] ?
                    LOCKED_BYTE : UNLOCKED_BYTE;
            end
        end
        // Drive status on falling edges, MSB first, repeating the byte
        if (!r_reg.cs2 && ck_fall && r_reg.cnt == CMD_BITS &&
            r_reg.op == OP_READ_LOCK && !r_reg.busy) begin
            if (r_reg.qpi) begin
                r_next.io_out = r_reg.out_sh[7:4];
                r_next.io_oe = 4'hF;
                r_next.out_sh = {r_reg.out_sh[3:0], r_reg.out_sh[7:4]};
            end else begin
                r_next.io_out = {2'h0, r_reg.out_sh[7], 1'b0};
                r_next.io_oe = 4'h2;
                r_next.out_sh = {r_reg.out_sh[6:0], r_reg.out_sh[7]};
            end
        end
        // Execute on chip select release; a partial instruction at most drops the armed state
        if (cs_rise) begin
            r_next.cnt = 6'h00;
            r_next.io_oe = 4'h0;
            r_next.io_out = 4'h0;
            if (!r_reg.busy && r_reg.cnt >= OPCODE_BITS) begin
                // Anything but a complete reset-arm instruction drops the armed state
                r_next.armed = 1'b0;
                if (r_reg.cnt == OPCODE_BITS) begin
                    case (r_reg.op)
                        OP_EXIT_QUAD: begin
                            // Write enable left alone
                            if (r_reg.qpi) begin
                                r_next.qpi = 1'b0;
                            end
                        end
                        OP_ENTER_QUAD: begin
                            if (quad_enable_bit_i) begin
                                r_next.qpi = 1'b1;
                            end
                        end
                        OP_GLOBAL_LOCK: begin
                            if (r_reg.write_enable_latch) begin
                                r_next.locks = '1;
                            end
                        end
                        OP_GLOBAL_UNLOCK: begin
                            if (r_reg.write_enable_latch) begin
                                r_next.locks = '0;
                            end
                        end
                        OP_RESET_ARM: begin
                            r_next.armed = 1'b1;
                        end
                        OP_RESET: begin
                            if (r_reg.armed) begin
                                // Power-on state; neighbours clear the rest
                                r_next.soft_reset = 1'b1;
                                r_next.busy = 1'b1;
                                r_next.rst_cnt = RESET_CYCLES - 10'h001;
                                r_next.write_enable_latch = 1'b0;
                                r_next.qpi = 1'b0;
                                r_next.locks = LOCKS_RESET;
                            end
                        end
                        default: begin
                        end
                    endcase
                end else if (r_reg.cnt == CMD_BITS && r_reg.write_enable_latch) begin
                    if (r_reg.op == OP_LOCK) begin
                        r_next.locks[blk] = 1'b1;
                    end else if (r_reg.op == OP_UNLOCK) begin
                        r_next.locks[blk] = 1'b0;
                    end
                end
            end
        end
        // Reset period count-down
        if (r_reg.busy) begin
            if (r_reg.rst_cnt == 10'h000) begin
                r_next.busy = 1'b0;
            end else begin
                r_next.rst_cnt = r_reg.rst_cnt - 10'h001;
            end
        end
        // Erase/program gate; block-protect result used when locks off
        if (pe_req_i) begin
            if (r_reg.busy || (lock_select_bit_i ?
                r_reg.locks[pe_addr_i[23:16]] : block_protect_hit_i)) begin
                r_next.pe_deny = 1'b1;
            end else begin
                r_next.pe_grant = 1'b1;
            end
        end
    end

    // State register; power-up leaves every block locked
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r_reg <= '0;
            r_reg.cs1 <= 1'b1;
            r_reg.cs2 <= 1'b1;
            r_reg.cs3 <= 1'b1;
            r_reg.locks <= LOCKS_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign io_o = r_reg.io_out;
    assign io_oe_o = r_reg.io_oe;
    assign pe_grant_o = r_reg.pe_grant;
    assign pe_deny_o = r_reg.pe_deny;
    assign write_enable_latch_o = r_reg.write_enable_latch;
    assign quad_instruction_mode_o = r_reg.qpi;
    assign soft_reset_o = r_reg.soft_reset;
    assign reset_busy_o = r_reg.busy;

    // Checks on the executed instructions and the erase/program gate
    localparam int RST_MAX = 1000;

    sequence cmd_end(logic [7:0] opc, logic [5:0] bits);
        cs_rise && !r_reg.busy && r_reg.cnt == bits && r_reg.op == opc;
    endsequence

    sequence reset_hold;
        r_reg.busy [*8] ##[1:RST_MAX] !r_reg.busy;
    endsequence

    quad_exit_a: assert property (
        cmd_end(OP_EXIT_QUAD, OPCODE_BITS) ##0 r_reg.qpi && !wel_set_i &&
        !wel_clear_i |=> !r_reg.qpi && r_reg.write_enable_latch == $past(r_reg.write_enable_latch))
        else $error("quad exit failed or touched write enable");
    quad_enter_a: assert property (
        cmd_end(OP_ENTER_QUAD, OPCODE_BITS) ##0 !r_reg.qpi &&
        !quad_enable_bit_i |=> !r_reg.qpi)
        else $error("quad mode entered without quad enable");
    block_lock_a: assert property (
        cmd_end(OP_LOCK, CMD_BITS) ##0 r_reg.write_enable_latch |=>
        r_reg.locks[$past(blk)])
        else $error("block lock not set");
    block_unlock_a: assert property (
        cmd_end(OP_UNLOCK, CMD_BITS) ##0 r_reg.write_enable_latch |=>
        !r_reg.locks[$past(blk)])
        else $error("block lock not cleared");
    wel_gate_a: assert property (
        cs_rise && !r_reg.write_enable_latch && !(r_reg.op == OP_RESET && r_reg.armed)
        |=> $stable(r_reg.locks))
        else $error("lock bits changed without write enable");
    global_lock_a: assert property (
        cmd_end(OP_GLOBAL_LOCK, OPCODE_BITS) ##0 r_reg.write_enable_latch |=> &r_reg.locks)
        else $error("global lock left a block open");
    global_unlock_a: assert property (
        cmd_end(OP_GLOBAL_UNLOCK, OPCODE_BITS) ##0 r_reg.write_enable_latch |=>
        r_reg.locks == '0)
        else $error("global unlock left a block locked");
    reset_pair_a: assert property (
        cmd_end(OP_RESET, OPCODE_BITS) ##0 r_reg.armed |=> soft_reset_o &&
        r_reg.busy && !r_reg.write_enable_latch && &r_reg.locks)
        else $error("armed reset not carried out");
    reset_disarm_a: assert property (
        cs_rise && !r_reg.busy && r_reg.cnt >= OPCODE_BITS &&
        r_reg.op != OP_RESET_ARM |=> !r_reg.armed)
        else $error("armed state kept after another instruction");
    reset_time_a: assert property (
        $rose(r_reg.busy) |-> reset_hold)
        else $error("reset period wrong length");
    pe_gate_a: assert property (
        pe_req_i && lock_select_bit_i && r_reg.locks[pe_addr_i[23:16]]
        |=> pe_deny_o && !pe_grant_o)
        else $error("locked block granted erase or program");
    // Gate, link output, reset-period, arm and write enable checks
    grant_open_a: assert property (
        pe_req_i && !r_reg.busy && !lock_select_bit_i && !block_protect_hit_i
        |=> pe_grant_o && !pe_deny_o)
        else $error("unprotected block refused erase or program");
    protect_bits_a: assert property (
        pe_req_i && !lock_select_bit_i && block_protect_hit_i
        |=> pe_deny_o && !pe_grant_o)
        else $error("block-protect hit granted erase or program");
    busy_refuse_a: assert property (
        cs_rise && r_reg.busy |=> $stable(r_reg.locks) &&
        $stable(r_reg.qpi) && $stable(r_reg.armed))
        else $error("instruction acted on during reset period");
    spi_drive_a: assert property (
        !r_reg.cs2 && ck_fall && r_reg.cnt == CMD_BITS && !r_reg.busy &&
        r_reg.op == OP_READ_LOCK && !r_reg.qpi
        |=> io_oe_o == 4'h2 && io_o[1] == $past(r_reg.out_sh[7]))
        else $error("lock byte bit not driven on the data output");
    quad_drive_a: assert property (
        !r_reg.cs2 && ck_fall && r_reg.cnt == CMD_BITS && !r_reg.busy &&
        r_reg.op == OP_READ_LOCK && r_reg.qpi
        |=> io_oe_o == 4'hF && io_o == $past(r_reg.out_sh[7:4]))
        else $error("lock byte nibble not driven on the data pins");
    lock_byte_a: assert property (
        !r_reg.cs2 && ck_rise && r_reg.cnt != CMD_BITS ##1
        r_reg.cnt == CMD_BITS && r_reg.op == OP_READ_LOCK
        |-> r_reg.out_sh[0] == r_reg.locks[blk] && r_reg.out_sh[7:1] == 7'h00)
        else $error("lock byte does not match the lock bit");
    arm_accept_a: assert property (
        cmd_end(OP_RESET_ARM, OPCODE_BITS) |=> r_reg.armed)
        else $error("reset-arm instruction not taken");
    wel_set_a: assert property (
        wel_set_i |=> r_reg.write_enable_latch || soft_reset_o)
        else $error("write enable set request lost");
endmodule

// [tb/flash_host_model.sv]
// Host controller model that frames instructions on the serial link
`timescale 1ns/100ps
module flash_host_model (
    input wire logic clk_i,
    input wire logic [3:0] io_o,
    input wire logic [3:0] io_oe_o,
    input wire logic reset_busy_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic [3:0] host_io_o
);
    // Link clock stands low between frames
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        host_io_o = 4'h0;
    end
    // Launch just after a system edge so sampling never races
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
        #10;
    endtask
    // One unit: set data, rise, look at the answer late in high phase
    task automatic unit(input logic [3:0] v, output logic [3:0] s);
        host_io_o = v;
        wait_clk(4);
        sclk_o = 1'b1;
        wait_clk(3);
        s = (io_oe_o & io_o) | (~io_oe_o & host_io_o); // Line level seen
        wait_clk(1);
        sclk_o = 1'b0;
    endtask
    // Whole frame: n bits of w, MSB first, then rn answer bits
    task automatic xfer(input logic [31:0] w, input int n, input int rn,
        input logic q, output logic [7:0] rd);
        logic [3:0] s;
        int step;
        step = q ? 4 : 1;
        rd = 8'h00;
        cs_n_o = 1'b0;
        wait_clk(4);
        for (int i = 0; i < n; i += step) begin
            unit(q ? w[31-i -: 4] : {~host_io_o[3:1], w[31-i]}, s);
        end
        // Released lines show the inverse, never a stale copy
        for (int j = 0; j < rn; j += step) begin
            unit(~host_io_o, s);
            rd = q ? {rd[3:0], s} : {rd[6:0], s[1]};
        end
        cs_n_o = 1'b1;
        host_io_o = ~host_io_o;
        wait_clk(8);
    endtask
    // Arm then reset, once the device is idle or 2000 cycles have passed
    task automatic reset_pair(input logic q);
        logic [7:0] rd;
        for (int k = 0; k < 2000 && reset_busy_i !== 1'b0; k++) begin
            wait_clk(1);
        end
        xfer({8'h66, 24'h0}, 8, 0, q, rd);
        xfer({8'h99, 24'h0}, 8, 0, q, rd);
    endtask
endmodule

// [tb/test_flash_lock_qpi_exit_reset_cmds.sv]
// Directed bench for the lock, quad-exit and reset instructions
`timescale 1ns/100ps
module test_flash_lock_qpi_exit_reset_cmds;
    import flash_lock_pkg::*;
    logic clk_i, rstn_i, cs_n, sclk, lsel, qe, bph, wset, wclr, pe_req;
    logic [3:0] host_io, io_i, io_o, io_oe_o;
    logic [23:0] pe_addr;
    logic pe_grant_o, pe_deny_o, wel_o, qpi_o, soft_reset_o, reset_busy_o;
    logic [7:0] rd;
    int err_count = 0, total_checks = 0, cyc = 0, pulses = 0, busy_cyc = 0;
    // Wire level: whoever enables drives
    assign io_i = (io_oe_o & io_o) | (~io_oe_o & host_io);
    flash_lock_cmd DUT (.clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n),
        .sclk_i(sclk), .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o),
        .lock_select_bit_i(lsel), .quad_enable_bit_i(qe),
        .block_protect_hit_i(bph), .wel_set_i(wset), .wel_clear_i(wclr),
        .pe_req_i(pe_req), .pe_addr_i(pe_addr), .pe_grant_o(pe_grant_o),
        .pe_deny_o(pe_deny_o), .write_enable_latch_o(wel_o),
        .quad_instruction_mode_o(qpi_o), .soft_reset_o(soft_reset_o),
        .reset_busy_o(reset_busy_o));
    flash_host_model host (.clk_i(clk_i), .io_o(io_o), .io_oe_o(io_oe_o),
        .reset_busy_i(reset_busy_o), .cs_n_o(cs_n), .sclk_o(sclk),
        .host_io_o(host_io));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // Pulse and busy tallies, plus the hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (soft_reset_o === 1'b1) pulses++;
        if (reset_busy_o === 1'b1) busy_cyc++;
        if (cyc == 30000) begin
            err_count++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] a,
        input int n, input logic q);
        host.xfer({op, a}, n, 0, q, rd);
    endtask
    task automatic rl(input logic [23:0] a, input logic q, logic [7:0] e);
        host.xfer({OP_READ_LOCK, a}, 32, 8, q, rd);
        chk("lock byte", e, rd);
        chk("oe idle", 8'h00, {4'h0, io_oe_o});
    endtask
    task automatic wel_pulse();
        wset = 1'b1;
        host.wait_clk(1);
        wset = 1'b0;
    endtask
    // Request taken at one edge, answered in the cycle after it
    task automatic pe(input logic [23:0] a, input logic g);
        pe_addr = a;
        pe_req = 1'b1;
        host.wait_clk(1);
        pe_req = 1'b0;
        // Answer stands only in the cycle after the taking edge
        chk("grant", {7'h0, g}, {7'h0, pe_grant_o});
        chk("deny", {7'h0, ~g}, {7'h0, pe_deny_o});
        host.wait_clk(1);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        {rstn_i, lsel, qe, bph, wset, wclr, pe_req} = 7'h00;
        pe_addr = 24'h000000;
        repeat (20) @(posedge clk_i);
        #10 rstn_i = 1'b1;
        host.wait_clk(4);
        rl(24'h050000, 1'b0, LOCKED_BYTE);
        cmd(OP_GLOBAL_UNLOCK, 24'h0, 8, 1'b0);
        rl(24'h060000, 1'b0, LOCKED_BYTE);
        wel_pulse();
        chk("wel", 8'h01, {7'h0, wel_o});
        cmd(OP_GLOBAL_UNLOCK, 24'h0, 8, 1'b0);
        rl(24'h06FFFF, 1'b0, UNLOCKED_BYTE);
        cmd(OP_LOCK, 24'h05ABCD, 32, 1'b0);
        rl(24'h050000, 1'b0, LOCKED_BYTE);
        rl(24'h060000, 1'b0, UNLOCKED_BYTE);
        lsel = 1'b1;
        pe(24'h051234, 1'b0);
        pe(24'h060000, 1'b1);
        lsel = 1'b0;
        bph = 1'b1;
        pe(24'h060000, 1'b0);
        bph = 1'b0;
        pe(24'h051234, 1'b1);
        cmd(OP_UNLOCK, 24'h05FFFF, 32, 1'b0);
        rl(24'h050000, 1'b0, UNLOCKED_BYTE);
        cmd(OP_ENTER_QUAD, 24'h0, 8, 1'b0);
        chk("qpi", 8'h00, {7'h0, qpi_o});
        qe = 1'b1;
        cmd(OP_ENTER_QUAD, 24'h0, 8, 1'b0);
        chk("qpi", 8'h01, {7'h0, qpi_o});
        cmd(OP_GLOBAL_LOCK, 24'h0, 8, 1'b1);
        rl(24'h0A0000, 1'b1, LOCKED_BYTE);
        cmd(OP_EXIT_QUAD, 24'h0, 8, 1'b1);
        chk("qpi", 8'h00, {7'h0, qpi_o});
        chk("wel", 8'h01, {7'h0, wel_o});
        // Clear alone drops write enable; a global unlock then does nothing
        wclr = 1'b1;
        host.wait_clk(1);
        wclr = 1'b0;
        chk("wel", 8'h00, {7'h0, wel_o});
        cmd(OP_GLOBAL_UNLOCK, 24'h0, 8, 1'b0);
        rl(24'h0A0000, 1'b0, LOCKED_BYTE);
        // Set and clear in one cycle: set wins
        {wset, wclr} = 2'h3;
        host.wait_clk(1);
        {wset, wclr} = 2'h0;
        chk("wel", 8'h01, {7'h0, wel_o});
        // Arm, interrupt with another instruction, then reset alone
        cmd(OP_RESET_ARM, 24'h0, 8, 1'b0);
        cmd(OP_GLOBAL_UNLOCK, 24'h0, 8, 1'b0);
        cmd(OP_RESET, 24'h0, 8, 1'b0);
        chk("pulses", 8'h00, 8'(pulses));
        cmd(OP_ENTER_QUAD, 24'h0, 8, 1'b0);
        host.reset_pair(1'b1);
        chk("pulses", 8'h01, 8'(pulses));
        chk("busy", 8'h01, {7'h0, reset_busy_o});
        chk("wel", 8'h00, {7'h0, wel_o});
        chk("qpi", 8'h00, {7'h0, qpi_o});
        wel_pulse();
        cmd(OP_GLOBAL_UNLOCK, 24'h0, 8, 1'b0);
        for (int k = 0; k < 1200 && reset_busy_o !== 1'b0; k++) begin
            host.wait_clk(1);
        end
        chk("busy span", 8'h01, {7'h0, busy_cyc >= int'(RESET_CYCLES)
            && busy_cyc <= int'(RESET_CYCLES) + 1});
        rl(24'h000000, 1'b0, LOCKED_BYTE);
        test_done();
    end
endmodule
